// *** common/scc_regs.vh ***
// Purpose: register map, field positions and timing counts of the clock source control
// Assumes: AXI4-Lite byte addresses are four times the register index
// Notes: one-time option straps select between the two warm-up lengths
`ifndef SCC_REGS_VH
`define SCC_REGS_VH

`define SCC_IDX_PWR 8'hC4
`define SCC_IDX_STAT 8'hC5
`define SCC_ADDR_PWR 10'h310
`define SCC_ADDR_STAT 10'h314
`define SCC_ADDR_CTRL 10'h318

`define SCC_PWR_XSEL 7
`define SCC_PWR_RCMD 6
`define SCC_PWR_RSRC 5
`define SCC_PWR_SOFF 4
`define SCC_PWR_MOFF 3
`define SCC_STAT_SRDY 7
`define SCC_STAT_MRDY 4

`define SCC_PWR_RESET 8'h40
`define SCC_STAT_RESET 8'h10

`define SCC_MAIN_WARM_SHORT 17'h01000
`define SCC_MAIN_WARM_LONG 17'h10000
`define SCC_SUB_WARM_SHORT 17'h00400
`define SCC_SUB_WARM_LONG 17'h10000

`define SCC_RESP_OKAY 2'b00
`define SCC_RESP_SLVERR 2'b10

`endif

// *** hdl/scc_clock_ctrl.v ***
// Purpose: system clock source selection and oscillator enables
// Assumes: oscillator clocks arrive as one-cycle tick pulses on aclk
// Notes: mux select is changed only when both sources are idle for a cycle
`timescale 1ns/1ps
`include "scc_regs.vh"

module scc_clock_ctrl (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write
  input wire [9:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [9:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Oscillators, power events and warm-up option straps
  input wire main_osc_tick,
  input wire sub_osc_tick,
  input wire pd_exit,
  input wire opt_main_long,
  input wire opt_sub_long,
  // Clock control outputs
  output reg main_osc_en_q,
  output reg sub_osc_en_q,
  output reg sel_crystal_q,
  output reg sel_rc_q,
  output reg cpu_stall_q
);

  localparam ST_RC = 4'b0001;
  localparam ST_TO_XT = 4'b0010;
  localparam ST_XT = 4'b0100;
  localparam ST_TO_RC = 4'b1000;

  reg [3:0] st_q;
  reg [3:0] st_d;
  reg xsel_q;
  reg rsrc_q;
  reg soff_q;
  reg moff_q;
  reg aw_hold_q;
  reg w_hold_q;
  reg [9:0] awaddr_q;
  reg [7:0] wdata_q;
  reg wlane_q;
  reg pd_stall_q;
  wire main_rdy;
  wire sub_rdy;
  wire main_restart;
  wire rc_mode;
  wire wr_go;
  wire [7:0] pwr_rd;
  wire [7:0] stat_rd;

  function is_mapped;
    input [9:0] a;
    begin
      is_mapped = (a == `SCC_ADDR_PWR) || (a == `SCC_ADDR_STAT);
    end
  endfunction

  // Main restart on enable or power-down exit, counted on its own ticks
  assign main_restart = pd_exit || (wr_go && awaddr_q == `SCC_ADDR_PWR && wlane_q &&
                        moff_q && !wdata_q[`SCC_PWR_MOFF]);

  scc_warmup u_main_warm (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(!moff_q),
    .restart(main_restart),
    .osc_tick(main_osc_tick),
    .target(opt_main_long ? `SCC_MAIN_WARM_LONG : `SCC_MAIN_WARM_SHORT),
    .ready_at_reset(1'b1),
    .ready_q(main_rdy)
  );

  scc_warmup u_sub_warm (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(!soff_q),
    .restart(1'b0),
    .osc_tick(sub_osc_tick),
    .target(opt_sub_long ? `SCC_SUB_WARM_LONG : `SCC_SUB_WARM_SHORT),
    .ready_at_reset(1'b0),
    .ready_q(sub_rdy)
  );

  assign rc_mode = (st_q != ST_XT);
  assign pwr_rd = {xsel_q, rc_mode, rsrc_q, soff_q, moff_q, 3'b000};
  assign stat_rd = {sub_rdy, 2'b00, main_rdy, 4'h0};
  assign wr_go = aw_hold_q && w_hold_q && !s_axi_bvalid;

  // Write channel: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 10'h000;
      wdata_q <= 8'h00;
      wlane_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `SCC_RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold_q && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready <= !w_hold_q && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[9:2], 2'b00};
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata[7:0];
        wlane_q <= s_axi_wstrb[0];
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(awaddr_q) ? `SCC_RESP_OKAY : `SCC_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Power management bits
  always @(posedge aclk) begin
    if (!aresetn) begin
      xsel_q <= 1'b0;
      rsrc_q <= 1'b0;
      soff_q <= 1'b0;
      moff_q <= 1'b0;
    end else if (wr_go && wlane_q && awaddr_q == `SCC_ADDR_PWR) begin
      rsrc_q <= wdata_q[`SCC_PWR_RSRC];
      soff_q <= wdata_q[`SCC_PWR_SOFF];
      if (!wdata_q[`SCC_PWR_XSEL])
        xsel_q <= 1'b0;
      else if (main_rdy && !moff_q)
        xsel_q <= 1'b1;
      if (!wdata_q[`SCC_PWR_MOFF])
        moff_q <= 1'b0;
      else if (st_q == ST_RC && !xsel_q)
        moff_q <= 1'b1;
    end
  end

  // Source switch: break before make so the mux never glitches
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_RC: if (xsel_q && main_rdy && !pd_stall_q) st_d = ST_TO_XT;
      ST_TO_XT: st_d = ST_XT;
      ST_XT: if (!xsel_q || pd_exit) st_d = ST_TO_RC;
      ST_TO_RC: st_d = ST_RC;
      default: st_d = ST_RC;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= ST_RC;
      sel_crystal_q <= 1'b0;
      sel_rc_q <= 1'b1;
      pd_stall_q <= 1'b0;
      cpu_stall_q <= 1'b0;
      main_osc_en_q <= 1'b1;
      sub_osc_en_q <= 1'b1;
    end else begin
      st_q <= st_d;
      sel_crystal_q <= (st_d == ST_XT);
      sel_rc_q <= (st_d == ST_RC);
      main_osc_en_q <= !moff_q;
      sub_osc_en_q <= !soff_q;
      if (pd_exit)
        pd_stall_q <= !rsrc_q && xsel_q;
      else if (main_rdy)
        pd_stall_q <= 1'b0;
      cpu_stall_q <= pd_exit ? (!rsrc_q && xsel_q) : (pd_stall_q && !main_rdy);
    end
  end

  // Read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `SCC_RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `SCC_RESP_OKAY;
        if ({s_axi_araddr[9:2], 2'b00} == `SCC_ADDR_PWR)
          s_axi_rdata <= {24'h000000, pwr_rd};
        else if ({s_axi_araddr[9:2], 2'b00} == `SCC_ADDR_STAT)
          s_axi_rdata <= {24'h000000, stat_rd};
        else begin
          s_axi_rdata <= 32'h00000000;
          s_axi_rresp <= `SCC_RESP_SLVERR;
        end
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // scc_clock_ctrl

// *** hdl/scc_warmup.v ***
// Purpose: warm-up counter for one oscillator
// Assumes: osc_tick is a one-cycle pulse per oscillator clock, synchronous to aclk
// Notes: restart clears the count and the ready flag at once
`timescale 1ns/1ps
`include "scc_regs.vh"

module scc_warmup (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Control
  input wire run,
  input wire restart,
  input wire osc_tick,
  input wire [16:0] target,
  input wire ready_at_reset,
  // Status
  output reg ready_q
);

  reg [16:0] cnt_q;

  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 17'h00000;
      ready_q <= 1'b0;
      if (ready_at_reset)
        ready_q <= 1'b1;
    end else if (restart || !run) begin
      cnt_q <= 17'h00000;
      ready_q <= 1'b0;
    end else if (!ready_q && osc_tick) begin
      if (cnt_q == target - 17'h00001)
        ready_q <= 1'b1;
      cnt_q <= cnt_q + 17'h00001;
    end
  end

endmodule // scc_warmup

// *** tb/scc_clock_ctrl_props.sv ***
// Purpose: assertions on the clock select, enable and stall outputs
// Assumes: one aclk domain, sync active-low reset
// Notes: a mux handover shows one idle cycle with both selects low
`timescale 1ns/1ps
module scc_chk (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Watched signals
  input wire pd_exit,
  input wire main_osc_en_q,
  input wire sel_crystal_q,
  input wire sel_rc_q,
  input wire cpu_stall_q
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_to_xtal;
    !sel_crystal_q ##1 sel_crystal_q;
  endsequence
  sequence s_to_rc;
    !sel_rc_q ##1 sel_rc_q;
  endsequence
  a_sel_onehot: assert property (!(sel_rc_q && sel_crystal_q))
    else $error("both clock selects high");
  a_rc_to_xtal: assert property ($fell(sel_rc_q) |-> s_to_xtal)
    else $error("bad handover to crystal");
  // Reset drops the crystal select; not a handover
  a_xtal_to_rc: assert property ($fell(sel_crystal_q) && $past(aresetn) |-> s_to_rc)
    else $error("bad handover to rc");
  a_xtal_needs_en: assert property ($rose(sel_crystal_q) |-> main_osc_en_q)
    else $error("crystal selected while disabled");
  a_off_on_rc: assert property (!main_osc_en_q |-> sel_rc_q)
    else $error("crystal off while not on rc");
  a_pd_to_rc: assert property (pd_exit && sel_crystal_q |-> ##[1:4] sel_rc_q)
    else $error("no drop to rc on resume");
  a_stall_en: assert property (cpu_stall_q |-> main_osc_en_q)
    else $error("stall with crystal stopped");
  a_stall_back: assert property ($fell(cpu_stall_q) && $past(aresetn) |-> ##[0:4] sel_crystal_q)
    else $error("no return to crystal after stall");
endmodule // scc_chk
bind scc_clock_ctrl scc_chk u_chk (.*);

// *** tb/scc_clock_ctrl_tb.sv ***
// Purpose: self-checking bench for the clock source control
// Assumes: short warm-up options until the last test switches both to long, random oscillator ticks
// Notes: tick counts kept here predict the ready flags
`timescale 1ns/1ps
module scc_clock_ctrl_tb;
  logic aclk = 0, aresetn = 0, pd_exit = 0, main_osc_tick = 0, sub_osc_tick = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  logic opt_main_long = 0, opt_sub_long = 0;
  logic [9:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire main_osc_en_q, sub_osc_en_q, sel_crystal_q, sel_rc_q, cpu_stall_q;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int errors = 0, checked = 0, mc = 0, sc = 0, m0, s0;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  localparam logic [9:0] P = 10'h310, S = 10'h314;
  always #12.5 aclk = ~aclk;
  scc_clock_ctrl u_scc_clock_ctrl (.s_axi_wstrb(4'hF), .*);
  // Seeded in the thread that draws, so the tick pattern repeats run to run
  initial begin
    void'($urandom(26));
    forever begin
      @(posedge aclk);
      main_osc_tick <= 1'($urandom % 2);
      sub_osc_tick <= 1'($urandom % 2);
    end
  end
  always @(posedge aclk) begin
    mc <= mc + main_osc_tick;
    sc <= sc + sub_osc_tick;
    if (s_axi_rvalid && s_axi_rready) chk("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
    if (s_axi_bvalid && s_axi_bready) chk("bresp", 34'(bq.pop_front()), 34'(s_axi_bresp));
  end
  task chk(string n, logic [33:0] e, logic [33:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task wr(input logic [9:0] a, input logic [7:0] d, input logic [1:0] e);
    bq.push_back(e);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 0;
  endtask
  task rd(input logic [9:0] a, input logic [33:0] e);
    rq.push_back(e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 0;
  endtask
  task pulse_pd;
    @(posedge aclk) pd_exit <= 1;
    @(posedge aclk) pd_exit <= 0;
    m0 = mc;
  endtask
  task give_verdict;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge aclk);
    errors++;
    give_verdict;
  end
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1;
    s0 = sc;
    rd(P, 34'h040);
    wr(S, 8'h00, 2'b00);
    rd(S, 34'h010);
    wr(10'h318, 8'h00, 2'b10);
    rd(10'h318, {2'b10, 32'h0});
    while (sc - s0 < 1000) @(posedge aclk);
    rd(S, 34'h010);
    while (sc - s0 < 1050) @(posedge aclk);
    rd(S, 34'h090);
    repeat (5) @(posedge aclk);
    wr(P, 8'h10, 2'b00);
    rd(S, 34'h010);
    chk("sub_en", 0, sub_osc_en_q);
    $display("test reset and sub warm-up done");
    wr(P, 8'h80, 2'b00);
    rd(P, 34'h080);
    chk("xtal_sel", 1, sel_crystal_q);
    wr(P, 8'h88, 2'b00);
    rd(P, 34'h080);
    wr(P, 8'h00, 2'b00);
    wr(P, 8'h08, 2'b00);
    rd(P, 34'h048);
    chk("main_en", 0, main_osc_en_q);
    wr(P, 8'h88, 2'b00);
    rd(P, 34'h048);
    $display("test select and disable done");
    wr(P, 8'h00, 2'b00);
    m0 = mc;
    rd(S, 34'h000);
    wr(P, 8'h80, 2'b00);
    rd(P, 34'h040);
    while (mc - m0 < 4070) @(posedge aclk);
    rd(S, 34'h080);
    while (mc - m0 < 4120) @(posedge aclk);
    rd(S, 34'h090);
    $display("test main warm-up done");
    wr(P, 8'h80, 2'b00);
    pulse_pd;
    rd(S, 34'h080);
    chk("stall", 1, cpu_stall_q);
    while (mc - m0 < 4120) @(posedge aclk);
    rd(P, 34'h080);
    chk("stall", 0, cpu_stall_q);
    wr(P, 8'hA0, 2'b00);
    pulse_pd;
    rd(S, 34'h080);
    chk("stall", 0, cpu_stall_q);
    chk("rc_sel", 1, sel_rc_q);
    $display("test power-down resume done");
    @(posedge aclk) opt_main_long <= 1;
    pulse_pd;
    while (mc - m0 < 4200) @(posedge aclk);
    rd(S, 34'h080);
    @(posedge aclk) opt_sub_long <= 1;
    wr(P, 8'h30, 2'b00);
    wr(P, 8'h20, 2'b00);
    s0 = sc;
    while (sc - s0 < 1100) @(posedge aclk);
    rd(S, 34'h000);
    $display("test long warm-up options done");
    give_verdict;
  end
endmodule // scc_clock_ctrl_tb
